// >>> hw/kms_pkg.sv
// Purpose: Constants and types for the keybed matrix scanner
// Assumes: 20 MHz system clock, synchronous active-high reset
// Notes: Operation list below
//
// Operation
// RULE1: Sense first and second contact of every key on two column groups
// RULE2: Phase high samples second-contact columns as key-on status of the row
// RULE3: Phase low samples second-contact columns as switch status of the row
// RULE4: Phase high captures first-contact columns as key-off status inputs
// RULE5: Phase low drives first-contact columns with LED data of the row
// RULE6: Four row-select lines pick the active key row and switch/LED row
// RULE7: Row-select lines also pick the external slider multiplexer channel
// RULE8: Sixteen rows by eleven columns cover 176 keys and 176 switches
// RULE9: Same sixteen-row scan serves 88 LEDs and 16 slider channels
// RULE10: Second select line gives extra decoding for other matrix layouts
// RULE11: Hold row and phase stable for programmable settling time before sampling
// RULE12: Release column drivers before the matrix may drive them; no contention
`default_nettype none

package kms_pkg;

   // ***********************************************
   // Geometry
   // ***********************************************
   localparam int KMS_ROWS = 16;
   localparam int KMS_COLS = 11;
   localparam int KMS_ROW_W = 4;
   localparam int KMS_MAP_W = KMS_ROWS * KMS_COLS;
   localparam int KMS_LED_ROWS = 8;
   localparam int KMS_LED_ROW_W = 3;
   localparam logic [KMS_ROW_W-1:0] KMS_LAST_ROW = 4'hf;

   // ***********************************************
   // Timing
   // ***********************************************
   localparam int KMS_CLK_PERIOD_NS = 50;
   localparam int KMS_GUARD_NS = 100;
   localparam int KMS_GUARD_CYC_I = (KMS_GUARD_NS + KMS_CLK_PERIOD_NS - 1) / KMS_CLK_PERIOD_NS;
   localparam int KMS_CNT_W = 9;
   localparam logic [KMS_CNT_W-1:0] KMS_GUARD_CYC = KMS_CNT_W'(KMS_GUARD_CYC_I < 1 ? 1 : KMS_GUARD_CYC_I);
   localparam logic [KMS_CNT_W-1:0] KMS_SYNC_LAT = 9'h002;
   localparam int KMS_SETTLE_W = 8;

   // ***********************************************
   // Reset values
   // ***********************************************
   localparam logic [KMS_ROW_W-1:0] KMS_ROW_RST = 4'h0;
   localparam logic KMS_PHASE_RST = 1'b0;
   localparam logic KMS_OE_N_RST = 1'b1;
   localparam logic [KMS_MAP_W-1:0] KMS_MAP_RST = '0;
   localparam logic [KMS_COLS-1:0] KMS_COL_RST = 11'h000;

   // ***********************************************
   // Scan states
   // ***********************************************
   typedef enum logic [2:0] {
      KMS_ST_IDLE = 3'b000,
      KMS_ST_KEY = 3'b001,
      KMS_ST_TURN_ON = 3'b010,
      KMS_ST_SW = 3'b011,
      KMS_ST_TURN_OFF = 3'b100
   } kms_state_t;

endpackage

`default_nettype wire

// >>> hw/kms_sync.sv
// Purpose: Two flip-flop synchroniser for a bus of pin inputs
// Assumes: Bits are independent levels
// Notes: First stage feeds only the second stage
`timescale 1ns/1ns
`default_nettype none

module kms_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);

   logic [W-1:0] meta_q;
   logic [W-1:0] meta_d;
   logic [W-1:0] dout_d;

   always_comb begin
      meta_d = din;
      dout_d = meta_q;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         meta_q <= '0;
         dout <= '0;
      end else begin
         meta_q <= meta_d;
         dout <= dout_d;
      end
   end

endmodule // kms_sync

`default_nettype wire

// >>> hw/kms_scanner.sv
// Purpose: Two-contact keybed, switch, LED and slider matrix scanner
// Assumes: Column pins are asynchronous; control inputs are on clk
// Notes: Each row runs a key phase then a switch/LED phase
`timescale 1ns/1ns
`default_nettype none

module kms_scanner
   import kms_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic scan_enable,
   input wire logic [KMS_SETTLE_W-1:0] settle_cycles,
   input wire logic extension_select_req,
   input wire logic led_we,
   input wire logic [KMS_LED_ROW_W-1:0] led_waddr,
   input wire logic [KMS_COLS-1:0] led_wdata,
   input wire logic [KMS_COLS-1:0] second_contact_columns,
   input wire logic first_contact_led_column_zero_i,
   output logic first_contact_led_column_zero_o,
   output logic first_contact_led_column_zero_oe_n,
   input wire logic [KMS_COLS-2:0] first_contact_led_columns_i,
   output logic [KMS_COLS-2:0] first_contact_led_columns_o,
   output logic [KMS_COLS-2:0] first_contact_led_columns_oe_n,
   output logic [KMS_ROW_W-1:0] scan_line_select,
   output logic matrix_phase_select,
   output logic matrix_extension_select,
   output logic [KMS_MAP_W-1:0] key_on_status,
   output logic [KMS_MAP_W-1:0] key_off_status,
   output logic [KMS_MAP_W-1:0] switch_status,
   output logic slider_sample,
   output logic scan_done,
   output logic scan_busy
);

   // ***********************************************
   // Column synchronisers
   // ***********************************************
   logic [KMS_COLS-1:0] second_s;
   logic [KMS_COLS-1:0] first_s;
   logic [KMS_COLS-1:0] first_raw;

   assign first_raw = {first_contact_led_columns_i, first_contact_led_column_zero_i};

   kms_sync #(.W(KMS_COLS)) u_sync_second (
      .clk(clk),
      .rst(rst),
      .din(second_contact_columns),
      .dout(second_s)
   );

   kms_sync #(.W(KMS_COLS)) u_sync_first (
      .clk(clk),
      .rst(rst),
      .din(first_raw),
      .dout(first_s)
   );

   // ***********************************************
   // LED data store
   // ***********************************************
   logic [KMS_COLS-1:0] led_q [KMS_LED_ROWS];
   logic [KMS_COLS-1:0] led_d [KMS_LED_ROWS];

   always_comb begin
      for (int i = 0; i < KMS_LED_ROWS; i++) begin
         led_d[i] = led_q[i];
      end
      if (led_we) begin
         led_d[led_waddr] = led_wdata; // RULE9
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         for (int i = 0; i < KMS_LED_ROWS; i++) begin
            led_q[i] <= KMS_COL_RST;
         end
      end else begin
         for (int i = 0; i < KMS_LED_ROWS; i++) begin
            led_q[i] <= led_d[i];
         end
      end
   end

   // ***********************************************
   // Scan sequencer
   // ***********************************************
   kms_state_t state_q;
   kms_state_t state_d;
   logic [KMS_CNT_W-1:0] cnt_q;
   logic [KMS_CNT_W-1:0] cnt_d;
   logic [KMS_ROW_W-1:0] row_q;
   logic [KMS_ROW_W-1:0] row_d;
   logic phase_q;
   logic phase_d;
   logic ext_q;
   logic ext_d;
   logic oe_n_q;
   logic oe_n_d;
   logic [KMS_COLS-1:0] col_out_q;
   logic [KMS_COLS-1:0] col_out_d;
   logic [KMS_MAP_W-1:0] key_on_q;
   logic [KMS_MAP_W-1:0] key_on_d;
   logic [KMS_MAP_W-1:0] key_off_q;
   logic [KMS_MAP_W-1:0] key_off_d;
   logic [KMS_MAP_W-1:0] switch_q;
   logic [KMS_MAP_W-1:0] switch_d;
   logic slider_q;
   logic slider_d;
   logic done_q;
   logic done_d;
   logic busy_q;
   logic busy_d;
   logic [KMS_CNT_W-1:0] settle_load;
   logic [KMS_COLS-1:0] led_row;

   always_comb begin
      if (settle_cycles == '0) begin
         settle_load = KMS_CNT_W'(1) + KMS_SYNC_LAT;
      end else begin
         settle_load = KMS_CNT_W'(settle_cycles) + KMS_SYNC_LAT; // RULE11
      end
      if (row_q < KMS_ROW_W'(KMS_LED_ROWS)) begin
         led_row = led_q[row_q[KMS_LED_ROW_W-1:0]]; // RULE9
      end else begin
         led_row = KMS_COL_RST;
      end
   end

   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      row_d = row_q;
      phase_d = phase_q;
      ext_d = ext_q;
      oe_n_d = oe_n_q;
      col_out_d = col_out_q;
      key_on_d = key_on_q;
      key_off_d = key_off_q;
      switch_d = switch_q;
      slider_d = 1'b0;
      done_d = 1'b0;
      busy_d = busy_q;
      case (state_q)
         KMS_ST_IDLE: begin
            oe_n_d = 1'b1;
            phase_d = 1'b0;
            busy_d = 1'b0;
            if (scan_enable) begin
               row_d = KMS_ROW_RST;
               phase_d = 1'b1; // RULE12
               ext_d = extension_select_req; // RULE10
               cnt_d = settle_load;
               busy_d = 1'b1;
               state_d = KMS_ST_KEY;
            end
         end
         KMS_ST_KEY: begin
            if (cnt_q != '0) begin
               cnt_d = cnt_q - KMS_CNT_W'(1); // RULE11
            end else begin
               key_on_d[row_q*KMS_COLS +: KMS_COLS] = second_s; // RULE2 RULE1
               key_off_d[row_q*KMS_COLS +: KMS_COLS] = first_s; // RULE4 RULE1
               phase_d = 1'b0;
               cnt_d = KMS_GUARD_CYC - KMS_CNT_W'(1);
               state_d = KMS_ST_TURN_ON;
            end
         end
         KMS_ST_TURN_ON: begin
            if (cnt_q != '0) begin
               cnt_d = cnt_q - KMS_CNT_W'(1); // RULE12
            end else begin
               oe_n_d = 1'b0; // RULE5
               col_out_d = led_row; // RULE5
               cnt_d = settle_load;
               state_d = KMS_ST_SW;
            end
         end
         KMS_ST_SW: begin
            if (cnt_q != '0) begin
               cnt_d = cnt_q - KMS_CNT_W'(1); // RULE11
            end else begin
               switch_d[row_q*KMS_COLS +: KMS_COLS] = second_s; // RULE3 RULE8
               slider_d = 1'b1; // RULE7
               oe_n_d = 1'b1; // RULE12
               cnt_d = KMS_GUARD_CYC - KMS_CNT_W'(1);
               state_d = KMS_ST_TURN_OFF;
            end
         end
         KMS_ST_TURN_OFF: begin
            if (cnt_q != '0) begin
               cnt_d = cnt_q - KMS_CNT_W'(1); // RULE12
            end else begin
               if (row_q == KMS_LAST_ROW) begin
                  done_d = 1'b1; // RULE8
               end
               if (row_q == KMS_LAST_ROW && !scan_enable) begin
                  row_d = KMS_ROW_RST;
                  state_d = KMS_ST_IDLE;
               end else begin
                  row_d = row_q + KMS_ROW_W'(1); // RULE6 RULE8
                  phase_d = 1'b1;
                  ext_d = extension_select_req; // RULE10
                  cnt_d = settle_load;
                  state_d = KMS_ST_KEY;
               end
            end
         end
         default: begin
            oe_n_d = 1'b1;
            state_d = KMS_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_q <= KMS_ST_IDLE;
         cnt_q <= '0;
         row_q <= KMS_ROW_RST;
         phase_q <= KMS_PHASE_RST;
         ext_q <= 1'b0;
         oe_n_q <= KMS_OE_N_RST;
         col_out_q <= KMS_COL_RST;
         key_on_q <= KMS_MAP_RST;
         key_off_q <= KMS_MAP_RST;
         switch_q <= KMS_MAP_RST;
         slider_q <= 1'b0;
         done_q <= 1'b0;
         busy_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         row_q <= row_d;
         phase_q <= phase_d;
         ext_q <= ext_d;
         oe_n_q <= oe_n_d;
         col_out_q <= col_out_d;
         key_on_q <= key_on_d;
         key_off_q <= key_off_d;
         switch_q <= switch_d;
         slider_q <= slider_d;
         done_q <= done_d;
         busy_q <= busy_d;
      end
   end

   // ***********************************************
   // Outputs
   // ***********************************************
   assign scan_line_select = row_q; // RULE6 RULE7
   assign matrix_phase_select = phase_q;
   assign matrix_extension_select = ext_q; // RULE10
   assign first_contact_led_column_zero_o = col_out_q[0];
   assign first_contact_led_columns_o = col_out_q[KMS_COLS-1:1];
   assign first_contact_led_column_zero_oe_n = oe_n_q; // RULE12
   assign first_contact_led_columns_oe_n = {(KMS_COLS-1){oe_n_q}}; // RULE12
   assign key_on_status = key_on_q;
   assign key_off_status = key_off_q;
   assign switch_status = switch_q;
   assign slider_sample = slider_q;
   assign scan_done = done_q;
   assign scan_busy = busy_q;

endmodule // kms_scanner

`default_nettype wire

// >>> dv/kms_scanner_asserts.sv
// Purpose: Port checks for the keybed matrix scanner
// Assumes: Bound to every kms_scanner instance
// Notes: Phase length is checked at settle_cycles of zero, one and three
`timescale 1ns/1ns
`default_nettype none
module kms_scanner_chk
   import kms_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [KMS_SETTLE_W-1:0] settle_cycles,
   input wire logic first_contact_led_column_zero_oe_n,
   input wire logic [KMS_COLS-2:0] first_contact_led_columns_oe_n,
   input wire logic [KMS_ROW_W-1:0] scan_line_select,
   input wire logic matrix_phase_select,
   input wire logic slider_sample,
   input wire logic scan_done,
   input wire logic scan_busy
);
   // ********
   // Checks
   // ********
   wire logic off = &{first_contact_led_columns_oe_n, first_contact_led_column_zero_oe_n};
   wire logic on = ~|{first_contact_led_columns_oe_n, first_contact_led_column_zero_oe_n};
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   property p_key_free; matrix_phase_select |-> off; endproperty
   a_key_free: assert property (p_key_free) else $error("columns driven in key phase");
   property p_all_same; off || on; endproperty
   a_all_same: assert property (p_all_same) else $error("column drivers split");
   property p_guard_on; $fell(matrix_phase_select) |-> off [*2] ##1 on; endproperty
   a_guard_on: assert property (p_guard_on) else $error("drive guard wrong");
   property p_guard_off; $rose(off) |-> !matrix_phase_select [*2]; endproperty
   a_guard_off: assert property (p_guard_off) else $error("release guard wrong");
   property p_row_hold; matrix_phase_select && $past(matrix_phase_select) |-> $stable(scan_line_select); endproperty
   a_row_hold: assert property (p_row_hold) else $error("row moved in key phase");
   property p_key_len; $rose(matrix_phase_select) && settle_cycles == 8'h01 |-> matrix_phase_select [*4] ##1
      !matrix_phase_select; endproperty
   a_key_len: assert property (p_key_len) else $error("key phase length wrong");
   property p_key_len0; $rose(matrix_phase_select) && settle_cycles == 8'h00 |-> matrix_phase_select [*4] ##1
      !matrix_phase_select; endproperty
   a_key_len0: assert property (p_key_len0) else $error("key phase length wrong at zero settle");
   property p_key_len3; $rose(matrix_phase_select) && settle_cycles == 8'h03 |-> matrix_phase_select [*6] ##1
      !matrix_phase_select; endproperty
   a_key_len3: assert property (p_key_len3) else $error("key phase length wrong at settle three");
   property p_slider; slider_sample |-> $rose(off) && !matrix_phase_select; endproperty
   a_slider: assert property (p_slider) else $error("slider pulse misplaced");
   property p_done; scan_done |-> $past(scan_line_select) == KMS_LAST_ROW; endproperty
   a_done: assert property (p_done) else $error("scan end not after last row");
   property p_start; $rose(scan_busy) |-> matrix_phase_select && scan_line_select == 4'h0; endproperty
   a_start: assert property (p_start) else $error("scan start wrong");
endmodule // kms_scanner_chk
bind kms_scanner kms_scanner_chk u_chk (.clk(clk), .rst(rst), .settle_cycles(settle_cycles),
   .first_contact_led_column_zero_oe_n(first_contact_led_column_zero_oe_n),
   .first_contact_led_columns_oe_n(first_contact_led_columns_oe_n), .scan_line_select(scan_line_select),
   .matrix_phase_select(matrix_phase_select), .slider_sample(slider_sample), .scan_done(scan_done),
   .scan_busy(scan_busy));
`default_nettype wire

// >>> dv/kms_matrix_model.sv
// Purpose: Key, switch and LED matrix beside the scanner
// Assumes: Columns have no pulls
// Notes: Undriven columns show the key-off pattern in phase high, else the inverse of the last value
`timescale 1ns/1ns
`default_nettype none
module kms_matrix_model
   import kms_pkg::*;
(
   input wire logic clk,
   input wire logic [KMS_ROW_W-1:0] row,
   input wire logic phase,
   input wire logic [KMS_COLS-1:0] drv_o,
   input wire logic [KMS_COLS-1:0] drv_oe_n,
   output logic [KMS_COLS-1:0] second_cols,
   output logic [KMS_COLS-1:0] first_cols
);
   // ********
   // Matrix
   // ********
   logic [KMS_COLS-1:0] led_seen [KMS_ROWS];
   function automatic logic [KMS_COLS-1:0] pat(input int k, input logic [3:0] r);
      pat = k == 0 ? 11'h555 ^ {7'h00, r} : k == 1 ? 11'h2aa ^ {r, 7'h00} : 11'h3c3 ^ {3'h0, r, 4'h0};
   endfunction
   always_comb begin
      second_cols = pat(phase ? 0 : 2, row);
      first_cols = (drv_oe_n & (phase ? pat(1, row) : ~drv_o)) | (~drv_oe_n & drv_o);
   end
   always @(posedge clk) begin
      if (drv_oe_n == 11'h000) led_seen[row] <= drv_o;
   end
endmodule // kms_matrix_model
`default_nettype wire

// >>> dv/tb_top.sv
// Purpose: Self-checking bench for the keybed matrix scanner
// Assumes: Settle of zero, one and three cycles; reset is also tried in mid-scan
// Notes: LED rows are table driven
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import kms_pkg::*;
   // ********
   // Bench
   // ********
   logic clk, rst, scan_enable, extension_select_req, led_we;
   logic [7:0] settle_cycles;
   logic [2:0] led_waddr;
   logic [10:0] led_wdata;
   wire logic [10:0] sc, fc, fo, foe;
   wire logic [3:0] row;
   wire logic ph, ext, slider, done, busy;
   wire logic [175:0] kon, koff, sw;
   int errors = 0;
   int checks_done = 0;
   int cyc = 0;
   logic [10:0] led_tab [8] = '{11'h001, 11'h7ff, 11'h400, 11'h2aa, 11'h555, 11'h000, 11'h0f0, 11'h30c};
   kms_scanner u_dut (.clk(clk), .rst(rst), .scan_enable(scan_enable), .settle_cycles(settle_cycles),
      .extension_select_req(extension_select_req), .led_we(led_we), .led_waddr(led_waddr), .led_wdata(led_wdata),
      .second_contact_columns(sc), .first_contact_led_column_zero_i(fc[0]), .first_contact_led_column_zero_o(fo[0]),
      .first_contact_led_column_zero_oe_n(foe[0]), .first_contact_led_columns_i(fc[10:1]),
      .first_contact_led_columns_o(fo[10:1]), .first_contact_led_columns_oe_n(foe[10:1]), .scan_line_select(row),
      .matrix_phase_select(ph), .matrix_extension_select(ext), .key_on_status(kon), .key_off_status(koff),
      .switch_status(sw), .slider_sample(slider), .scan_done(done), .scan_busy(busy));
   kms_matrix_model u_model (.clk(clk), .row(row), .phase(ph), .drv_o(fo), .drv_oe_n(foe), .second_cols(sc),
      .first_cols(fc));
   function automatic logic [10:0] pat(input int k, input int r);
      pat = k == 0 ? 11'h555 ^ 11'(r) : k == 1 ? 11'h2aa ^ 11'(r << 7) : 11'h3c3 ^ 11'(r << 4);
   endfunction
   task automatic chk(input logic [175:0] got, input logic [175:0] exp);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic conclude();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic run_scan(input logic e, input logic [7:0] s);
      int n;
      int k;
      n = 0;
      @(posedge clk);
      extension_select_req <= e;
      settle_cycles <= s;
      scan_enable <= 1'b1;
      @(posedge clk);
      scan_enable <= 1'b0;
      for (k = 0; k < 600 && done !== 1'b1; k++) begin
         @(posedge clk);
         #1;
         if (slider === 1'b1) begin
            chk(row, n);
            n++;
         end
      end
      chk(n, 16);
      @(posedge clk);
      #1;
      chk({ph, busy}, 2'b00);
      chk(ext, e);
      for (k = 0; k < 16; k++) begin
         chk(kon[k*11+:11], pat(0, k));
         chk(koff[k*11+:11], pat(1, k));
         chk(sw[k*11+:11], pat(2, k));
         chk(u_model.led_seen[k], k < 8 ? led_tab[k] : 11'h000);
      end
   endtask
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         errors++;
         conclude();
      end
   end
   initial begin
      rst = 1'b1;
      scan_enable = 1'b0;
      extension_select_req = 1'b0;
      led_we = 1'b0;
      settle_cycles = 8'h01;
      led_waddr = 3'h0;
      led_wdata = 11'h000;
      repeat (8) @(posedge clk);
      #1;
      chk(foe, 11'h7ff);
      chk({ph, busy}, 2'b00);
      chk(kon, 176'h0);
      for (int i = 0; i < 8; i++) begin
         @(posedge clk);
         rst <= 1'b0;
         led_we <= 1'b1;
         led_waddr <= 3'(i);
         led_wdata <= led_tab[i];
      end
      @(posedge clk);
      led_we <= 1'b0;
      run_scan(1'b1, 8'h01);
      run_scan(1'b0, 8'h00);
      run_scan(1'b0, 8'h03);
      // Reset in mid-scan during the key phase of row 1, while the columns are released
      @(posedge clk);
      scan_enable <= 1'b1;
      repeat (20) @(posedge clk);
      rst <= 1'b1;
      scan_enable <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk(foe, 11'h7ff);
      chk({ph, busy, done, slider, row}, 8'h00);
      chk(kon, 176'h0);
      chk(koff, 176'h0);
      chk(sw, 176'h0);
      @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      conclude();
   end
endmodule // tb_top
`default_nettype wire
